// [shared/ssq_pkg.sv]
`default_nettype none

package ssq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_PMC = 2'h0;  // power_mode_ctrl_reg
  localparam logic [1:0] ADDR_OPT = 2'h1;  // Stop options
  localparam logic [1:0] ADDR_DBG = 2'h2;  // debug_ctrl_status_reg
  localparam logic [1:0] ADDR_STA = 2'h3;  // Sequencer status

  // Field positions in power_mode_ctrl_reg
  localparam int PMC_PPD_SEL   = 0;  // partial_powerdown_select
  localparam int PMC_ACK       = 1;  // powerdown_ack, write-one
  localparam int PMC_WAKE_FLAG = 2;  // powerdown_wake_flag
  localparam int PMC_LV_KEEP   = 3;  // lowvolt_stop_keep
  localparam int PMC_LV_ON     = 4;  // lowvolt_detect_on

  // Field positions in the option register
  localparam int OPT_STOP_ALLOW = 0;  // stop_allow
  localparam int OPT_OSC_KEEP   = 1;  // osc_keep_in_stop
  localparam int OPT_ADC_ASYNC  = 2;  // converter_async_clock
  localparam int OPT_RATE_LO    = 4;  // periodic_wake_rate_sel
  localparam int RATE_W         = 3;

  // Field position in debug_ctrl_status_reg
  localparam int DBG_ALLOW = 7;  // debug_mode_allow

  // Writable bits and values after reset
  localparam logic [7:0] PMC_WMASK = 8'h19;
  localparam logic [7:0] OPT_WMASK = 8'h77;
  localparam logic [7:0] DBG_WMASK = 8'h80;
  localparam logic [7:0] PMC_RST   = 8'h00;
  localparam logic [7:0] OPT_RST   = 8'h00;
  localparam logic [7:0] DBG_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;         // 25 MHz system clock
  localparam int WAKE_TICK_NS  = 1_000_000;  // 1 kHz wake clock
  localparam int WAKE_DIV_CYC  = WAKE_TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 15;
  localparam logic [2:0] WAKE_RST_CYC = 3'h4;  // Restart pulse length

  // Wake timer periods in 1 kHz ticks, index is the rate select
  localparam logic [10:0] RTI_TICKS [8] = '{
    11'h000, 11'h008, 11'h020, 11'h040,
    11'h080, 11'h100, 11'h200, 11'h400};

  // ----------------------------------------------------------------
  // Pins and states
  // ----------------------------------------------------------------
  localparam int PIN_W = 8;
  localparam logic [PIN_W-1:0] PIN_RST = 8'h00;  // Inputs, undriven

  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,  // Normal execution
    ST_LIGHT   = 5'h02,  // Light standby stop
    ST_DEEP    = 5'h04,  // Partial power-down stop
    ST_RESTART = 5'h08,  // Power-on style restart
    ST_BKGD    = 5'h10   // Active background mode
  } ssq_state_t;

endpackage : ssq_pkg

`default_nettype wire

// [core/ssq_wake_timer.sv]
`default_nettype none

module ssq_wake_timer
  import ssq_pkg::*;
#(
  parameter int unsigned WAKE_DIV = WAKE_DIV_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [RATE_W-1:0] rate_sel,
  output logic                   wake_osc_on,
  output logic                   rti_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div;    // Cycles within one wake tick
    logic [10:0]      ticks;  // Wake ticks since last event
    logic             osc;    // Wake clock running
    logic             pulse;  // Timer event
  } ssq_wt_t;

  ssq_wt_t s, next_s;

  // Divider makes the 1 kHz enable, counter makes the event
  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    next_s.osc = (rate_sel != 3'h0);
    if (!next_s.osc) begin
      // Clock off saves power, so nothing may count
      next_s.div = '0;
      next_s.ticks = '0;
    end else if (s.div == DIV_W'(WAKE_DIV - 1)) begin
      next_s.div = '0;
      if (s.ticks + 11'h001 >= RTI_TICKS[rate_sel]) begin
        next_s.ticks = '0;
        next_s.pulse = 1'b1;
      end else begin
        next_s.ticks = s.ticks + 11'h001;
      end
    end else begin
      next_s.div = s.div + DIV_W'(1);
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wake_osc_on = s.osc;
  assign rti_pulse = s.pulse;

  a_rate_off_quiet:
  assert property (@(posedge clk) disable iff (sys_rst)
    (rate_sel == 3'h0) |=> !rti_pulse && !wake_osc_on)
    else $error("wake timer active with rate zero");

endmodule : ssq_wake_timer

`default_nettype wire

// [core/ssq_pin_hold.sv]
`default_nettype none

module ssq_pin_hold
  import ssq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             hold,
  input  wire logic [PIN_W-1:0] port_out,
  input  wire logic [PIN_W-1:0] port_oe,
  input  wire logic [PIN_W-1:0] periph_out,
  input  wire logic [PIN_W-1:0] periph_oe,
  input  wire logic [PIN_W-1:0] periph_en,
  output logic      [PIN_W-1:0] pin_out,
  output logic      [PIN_W-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // Per-pin owner select
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] live_out;  // Value the owner wants now
  logic [PIN_W-1:0] live_oe;   // Enable the owner wants now

  // Disabled peripheral hands the pin back to the port
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    assign live_out[i] = periph_en[i] ? periph_out[i] : port_out[i];
    assign live_oe[i]  = periph_en[i] ? periph_oe[i]  : port_oe[i];
  end

  typedef struct packed {
    logic [PIN_W-1:0] out;  // Pad value
    logic [PIN_W-1:0] oe;   // Pad enable
  } ssq_ph_t;

  ssq_ph_t s, next_s;

  // Frozen while held, so reset port values never reach the pad
  always_comb begin
    next_s = s;
    if (!hold) begin
      next_s.out = live_out;
      next_s.oe = live_oe;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.out <= PIN_RST;
      s.oe <= PIN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.out;
  assign pin_oe = s.oe;

  a_held_stable:
  assert property (@(posedge clk) disable iff (sys_rst)
    hold |=> $stable(pin_out) && $stable(pin_oe))
    else $error("held pin changed");

  a_release_live:
  assert property (@(posedge clk) disable iff (sys_rst)
    !hold |=> pin_out == $past(live_out) && pin_oe == $past(live_oe))
    else $error("released pin does not follow owner");

endmodule : ssq_pin_hold

`default_nettype wire

// [core/ssq_stop_seq.sv]
// Chosen here: the plain strobed port and the placing of the registers.
`default_nettype none

module ssq_stop_seq
  import ssq_pkg::*;
#(
  parameter int unsigned WAKE_DIV = WAKE_DIV_CYC
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [1:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             stop_exec,
  input  wire logic             reset_pin_n,
  input  wire logic             ext_irq_pin_n,
  input  wire logic             ext_irq_req,
  input  wire logic             lvd_irq,
  input  wire logic             adc_irq,
  input  wire logic             kbi_irq,
  input  wire logic             sci_irq,
  input  wire logic             bdc_background,
  input  wire logic             bdc_mem_status,
  input  wire logic             bdc_go,
  input  wire logic [PIN_W-1:0] port_out,
  input  wire logic [PIN_W-1:0] port_oe,
  input  wire logic [PIN_W-1:0] periph_out,
  input  wire logic [PIN_W-1:0] periph_oe,
  input  wire logic [PIN_W-1:0] periph_en,
  output logic      [PIN_W-1:0] pin_out,
  output logic      [PIN_W-1:0] pin_oe,
  output logic                  cpu_clk_en,
  output logic                  periph_clk_en,
  output logic                  bdc_clk_en,
  output logic                  osc_run,
  output logic                  icg_standby,
  output logic                  core_power_off,
  output logic                  reg_standby,
  output logic                  adc_standby,
  output logic                  kbi_off,
  output logic                  in_stop,
  output logic                  sys_restart,
  output logic                  take_reset_vec,
  output logic                  take_irq_vec,
  output logic                  illegal_op_rst,
  output logic                  bdc_stop_err,
  output logic                  rti_irq,
  output logic                  wake_osc_on
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    ssq_state_t st;        // Sequencer mode
    logic [7:0] pmc;       // Power mode control bits
    logic [7:0] opt;       // Stop option bits
    logic [7:0] dbg;       // Debug control bits
    logic       flag;      // Woke from deep stop
    logic       hold;      // Pin latches closed
    logic [2:0] rcnt;      // Restart cycles left
    logic [7:0] rdata;     // Read answer
    logic       cpu_clk;   // Registered outputs follow
    logic       per_clk;
    logic       bdc_clk;
    logic       osc;
    logic       icg_sb;
    logic       core_off;
    logic       reg_sb;
    logic       adc_sb;
    logic       kbi_off;
    logic       stopped;
    logic       restart;
    logic       rst_vec;
    logic       irq_vec;
    logic       illegal;
    logic       bdc_err;
    logic       periodic_wake_timer;
  } ssq_seq_t;

  ssq_seq_t s, next_s;

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  logic       rti_pulse;   // Wake timer event
  logic       lv_stop;     // Low-volt detector kept in stop
  logic       dbg_on;      // Debug allowed
  logic       deep_ok;     // A stop would go deep
  logic       ack_wr;      // Acknowledge strobe
  logic       deep_wake;   // Deep stop wake source
  logic       light_irq;   // Light stop interrupt source
  logic [7:0] pmc_view;    // Control register as read

  assign lv_stop = s.pmc[PMC_LV_KEEP] & s.pmc[PMC_LV_ON];
  assign dbg_on = s.dbg[DBG_ALLOW];
  // Debug or low-volt in stop downgrade to light
  assign deep_ok = s.pmc[PMC_PPD_SEL] & s.opt[OPT_STOP_ALLOW]
                 & ~lv_stop & ~dbg_on;
  assign ack_wr = reg_wr & (reg_addr == ADDR_PMC)
                & reg_wdata[PMC_ACK];
  // Irq pin is taken as active low whatever its setup
  assign deep_wake = ~reset_pin_n | ~ext_irq_pin_n | rti_pulse;
  // Keypad event only counts while the unit is powered
  assign light_irq = rti_pulse | lvd_irq | adc_irq | ext_irq_req
                   | kbi_irq | sci_irq;

  // Flag is kept apart from stored bits, merged for reads
  always_comb begin
    pmc_view = s.pmc;
    pmc_view[PMC_WAKE_FLAG] = s.flag;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // One-cycle pulses default low
    next_s.rdata = 8'h00;
    next_s.rst_vec = 1'b0;
    next_s.irq_vec = 1'b0;
    next_s.illegal = 1'b0;
    next_s.bdc_err = 1'b0;
    next_s.periodic_wake_timer = rti_pulse;

    // Register writes; acknowledge bit itself is never stored
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PMC: next_s.pmc = reg_wdata & PMC_WMASK;
        ADDR_OPT: next_s.opt = reg_wdata & OPT_WMASK;
        ADDR_DBG: next_s.dbg = reg_wdata & DBG_WMASK;
        ADDR_STA: ;  // Read only
      endcase
    end
    // Writing one opens latches and clears flag; zero does nothing
    if (ack_wr) begin
      next_s.flag = 1'b0;
      next_s.hold = 1'b0;
    end

    // Read answer, registered for the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PMC: next_s.rdata = pmc_view;
        ADDR_OPT: next_s.rdata = s.opt;
        ADDR_DBG: next_s.rdata = s.dbg;
        ADDR_STA: next_s.rdata = {2'h0, s.hold, s.st};
      endcase
    end

    // Status commands get an error while the core sleeps
    if (s.st == ST_LIGHT || s.st == ST_DEEP) begin
      next_s.bdc_err = bdc_mem_status;
    end

    // Mode sequencing; the flag set below wins over a same-cycle
    // acknowledge because it is written last
    unique case (s.st)
      ST_RUN: begin
        if (stop_exec) begin
          if (!s.opt[OPT_STOP_ALLOW]) begin
            // Stop not allowed: illegal opcode reset
            next_s.illegal = 1'b1;
            next_s.st = ST_RESTART;
            next_s.rcnt = WAKE_RST_CYC;
          end else if (deep_ok) begin
            next_s.st = ST_DEEP;
            next_s.hold = 1'b1;
          end else begin
            next_s.st = ST_LIGHT;
          end
        end
      end
      ST_LIGHT: begin
        // All state kept, nothing latched at the pads
        if (!reset_pin_n) begin
          next_s.st = ST_RESTART;
          next_s.rcnt = WAKE_RST_CYC;
        end else if (bdc_background && dbg_on) begin
          next_s.st = ST_BKGD;
        end else if (light_irq) begin
          next_s.st = ST_RUN;
          next_s.irq_vec = 1'b1;
        end
      end
      ST_DEEP: begin
        if (deep_wake) begin
          next_s.st = ST_RESTART;
          next_s.rcnt = WAKE_RST_CYC;
          next_s.flag = 1'b1;
        end
      end
      ST_RESTART: begin
        // Registers return to reset values; flag and latches stay
        next_s.pmc = PMC_RST;
        next_s.opt = OPT_RST;
        next_s.dbg = DBG_RST;
        if (s.rcnt == 3'h1) begin
          next_s.st = ST_RUN;
          next_s.rst_vec = 1'b1;
        end
        next_s.rcnt = s.rcnt - 3'h1;
      end
      ST_BKGD: begin
        if (bdc_go) begin
          next_s.st = ST_RUN;
        end
      end
    endcase

    // ----------------------------------------------------------
    // Power and clock outputs follow the coming mode
    // ----------------------------------------------------------
    next_s.stopped = (next_s.st == ST_LIGHT) || (next_s.st == ST_DEEP);
    next_s.core_off = (next_s.st == ST_DEEP);
    next_s.cpu_clk = ~next_s.stopped;
    // Peripheral clocks stop in any stop, debug or not
    next_s.per_clk = ~next_s.stopped;
    // Debug logic stays clocked when allowed
    next_s.bdc_clk = ~next_s.stopped | next_s.dbg[DBG_ALLOW];
    // Oscillator may run only in light stop
    next_s.osc = ~next_s.stopped
               | ((next_s.st == ST_LIGHT)
                  & (next_s.opt[OPT_OSC_KEEP] | next_s.dbg[DBG_ALLOW]));
    next_s.icg_sb = (next_s.st == ST_LIGHT) & ~next_s.dbg[DBG_ALLOW];
    // Regulator stays up for debug or low-volt
    next_s.reg_sb = next_s.stopped & ~next_s.dbg[DBG_ALLOW]
                  & ~(next_s.pmc[PMC_LV_KEEP] & next_s.pmc[PMC_LV_ON]);
    // Async converter clock only helps in light stop
    next_s.adc_sb = (next_s.st == ST_DEEP)
                  | ((next_s.st == ST_LIGHT)
                     & ~next_s.opt[OPT_ADC_ASYNC]);
    next_s.kbi_off = (next_s.st == ST_DEEP);
    // Restart resets clock gen, converter, keypad
    next_s.restart = (next_s.st == ST_RESTART);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= ST_RUN;
      s.pmc <= PMC_RST;
      s.opt <= OPT_RST;
      s.dbg <= DBG_RST;
      s.cpu_clk <= 1'b1;
      s.per_clk <= 1'b1;
      s.bdc_clk <= 1'b1;
      s.osc <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Children
  // ----------------------------------------------------------------
  ssq_wake_timer #(
    .WAKE_DIV    (WAKE_DIV)
  ) u_timer (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rate_sel    (s.opt[OPT_RATE_LO +: RATE_W]),
    .wake_osc_on (wake_osc_on),
    .rti_pulse   (rti_pulse)
  );

  // Pad latch sees the port values live once released
  ssq_pin_hold u_pins (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .hold        (s.hold),
    .port_out    (port_out),
    .port_oe     (port_oe),
    .periph_out  (periph_out),
    .periph_oe   (periph_oe),
    .periph_en   (periph_en),
    .pin_out     (pin_out),
    .pin_oe      (pin_oe)
  );

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign cpu_clk_en = s.cpu_clk;
  assign periph_clk_en = s.per_clk;
  assign bdc_clk_en = s.bdc_clk;
  assign osc_run = s.osc;
  assign icg_standby = s.icg_sb;
  assign core_power_off = s.core_off;
  assign reg_standby = s.reg_sb;
  assign adc_standby = s.adc_sb;
  assign kbi_off = s.kbi_off;
  assign in_stop = s.stopped;
  assign sys_restart = s.restart;
  assign take_reset_vec = s.rst_vec;
  assign take_irq_vec = s.irq_vec;
  assign illegal_op_rst = s.illegal;
  assign bdc_stop_err = s.bdc_err;
  assign rti_irq = s.periodic_wake_timer;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_deep_entry:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_RUN && stop_exec && deep_ok
    |=> s.st == ST_DEEP && s.hold && core_power_off)
    else $error("deep stop not entered");

  a_lowvolt_light:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_RUN && stop_exec && s.opt[OPT_STOP_ALLOW] && lv_stop
    |=> s.st == ST_LIGHT && !reg_standby)
    else $error("low-volt stop not light");

  a_debug_light:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_RUN && stop_exec && s.opt[OPT_STOP_ALLOW] && dbg_on
    |=> s.st == ST_LIGHT && bdc_clk_en && osc_run)
    else $error("debug stop not light");

  a_illegal_stop:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_RUN && stop_exec && !s.opt[OPT_STOP_ALLOW]
    |=> illegal_op_rst && s.st == ST_RESTART)
    else $error("illegal stop not reset");

  a_deep_wake:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_DEEP && !ext_irq_pin_n
    |=> s.flag && s.hold && sys_restart)
    else $error("deep wake missing flag");

  a_restart_len:
  assert property (@(posedge clk) disable iff (sys_rst)
    $rose(sys_restart) |-> sys_restart [*4] ##1 take_reset_vec)
    else $error("restart length wrong");

  a_ack_release:
  assert property (@(posedge clk) disable iff (sys_rst)
    ack_wr && s.st == ST_RUN && !stop_exec |=> !s.flag && !s.hold)
    else $error("acknowledge did not release");

  a_stop_clocks:
  assert property (@(posedge clk) disable iff (sys_rst)
    in_stop |-> !periph_clk_en && !cpu_clk_en)
    else $error("clock running in stop");

  a_deep_osc_off:
  assert property (@(posedge clk) disable iff (sys_rst)
    core_power_off |-> !osc_run && kbi_off && adc_standby)
    else $error("deep stop left blocks on");

  a_light_irq_exit:
  assert property (@(posedge clk) disable iff (sys_rst)
    s.st == ST_LIGHT && reset_pin_n && !bdc_background && sci_irq
    |=> take_irq_vec && s.st == ST_RUN)
    else $error("light stop irq exit wrong");

endmodule : ssq_stop_seq

`default_nettype wire

// [test/tb_ssq_stop_seq.sv]
`default_nettype none
module tb_ssq_stop_seq
  import ssq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals, all ports hooked up by matching names
  // ------------------------------------------------------------
  logic       clk, sys_rst, reg_wr, reg_rd;  // Clock, bus strobes
  logic       reset_pin_n, ext_irq_pin_n;    // Active low pins
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port_out, port_oe, periph_out;
  logic [7:0] periph_oe, periph_en, pin_out, pin_oe;
  logic [4:0] irqv;                          // Light-stop wake sources
  logic [3:0] pv;                            // Stop and debug pulses
  logic [15:0] held;                         // Pins frozen at entry
  wire logic ext_irq_req, lvd_irq, adc_irq, kbi_irq, sci_irq;
  wire logic stop_exec, bdc_background, bdc_mem_status, bdc_go;
  logic cpu_clk_en, periph_clk_en, bdc_clk_en, osc_run, icg_standby,
        core_power_off, reg_standby, adc_standby, kbi_off, in_stop,
        sys_restart, take_reset_vec, take_irq_vec, illegal_op_rst,
        bdc_stop_err, rti_irq, wake_osc_on;
  int   miscompares, cmp_count, cycles, seed;
  wire logic [9:0] stat = {cpu_clk_en, icg_standby, in_stop,
    core_power_off, kbi_off, periph_clk_en, osc_run, reg_standby,
    bdc_clk_en, adc_standby};
  logic rti_seen = 1'b0;                     // Wake timer event seen
  assign {ext_irq_req, lvd_irq, adc_irq, kbi_irq, sci_irq} = irqv;
  assign {stop_exec, bdc_background, bdc_mem_status, bdc_go} = pv;
  // Short divider keeps the wake timer within a few dozen cycles
  ssq_stop_seq #(.WAKE_DIV(4)) i_ssq_stop_seq (.*);
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    pv <= v;
    @(posedge clk);
    pv <= 4'h0;
    #1;
  endtask : pulse
  // Model of who owns each pin: peripheral when enabled, else port
  function automatic logic [15:0] pins();
    return {(periph_en & periph_oe) | (~periph_en & port_oe),
            (periph_en & periph_out) | (~periph_en & port_out)};
  endfunction : pins
  task automatic shuffle();
    @(posedge clk);
    {port_out, port_oe, periph_out, periph_oe} <= $random(seed);
    periph_en <= 8'($random(seed));
    repeat (3) @(posedge clk);
    #1;
  endtask : shuffle
  // Counts restart cycles until the reset vector is taken
  task automatic restart();
    int n;
    n = 0;
    for (int k = 0; k < 200 && take_reset_vec !== 1'b1; k++) begin
      n += int'(sys_restart === 1'b1);
      @(posedge clk);
      {reset_pin_n, ext_irq_pin_n} <= 2'b11;
      #1;
    end
    chk(16'(n), 16'd4);
  endtask : restart
  task automatic enter(input logic [7:0] opt, pmc, dbg);
    logic d, k;
    logic [9:0] e;
    wr(ADDR_OPT, opt);
    wr(ADDR_DBG, dbg);
    wr(ADDR_PMC, pmc);
    k = pmc[3] & pmc[4];
    d = pmc[0] & ~k & ~dbg[7];
    // Clocks, standby and power flags expected in the coming stop
    e = {1'b0, ~d & ~dbg[7], 1'b1, d, d, 1'b0,
         ~d & (opt[1] | dbg[7]), ~dbg[7] & ~k, dbg[7], d | ~opt[2]};
    pulse(4'h8);
    chk(stat[9:4], e[9:4]);
    chk(stat[3:0], e[3:0]);
  endtask : enter
  task automatic finish_test();
    $display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang anywhere ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // Wake timer events are one-cycle pulses, so remember that one came
  always @(posedge clk) begin
    rti_seen <= rti_seen | (rti_irq === 1'b1);
  end
  initial begin
    seed = 32'hb3561449;
    {sys_rst, reset_pin_n, ext_irq_pin_n} = 3'b111;
    {reg_wr, reg_rd, reg_addr, reg_wdata, irqv, pv} = '0;
    {port_out, port_oe, periph_out, periph_oe, periph_en} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    wr(ADDR_STA, 8'hff);
    rd(ADDR_STA, 8'h01);
    rd(ADDR_PMC, PMC_RST);
    pulse(4'h8);
    chk(illegal_op_rst, 1'b1);
    restart();
    // Deep stop, woken by the wake timer at rate one
    shuffle();
    held = pins();
    enter(8'h13, 8'h11, 8'h00);
    shuffle();
    chk({pin_oe, pin_out}, held);
    chk(wake_osc_on, 1'b1);
    restart();
    chk({rti_seen, wake_osc_on}, 16'h0002);
    rd(ADDR_OPT, OPT_RST);
    wr(ADDR_PMC, 8'h00);
    rd(ADDR_PMC, 8'h04);
    chk({pin_oe, pin_out}, held);
    // Software puts the saved port values back before acknowledging
    @(posedge clk);
    {port_oe, port_out} <= held;
    wr(ADDR_PMC, 8'h02);
    rd(ADDR_PMC, 8'h00);
    chk({pin_oe, pin_out}, pins());
    // Light stop left by each of the five irqv interrupt sources in turn, wake timer not among them
    for (int i = 0; i < 5; i++) begin
      enter(8'h01 | (8'(i << 1) & 8'h06), 8'h00, 8'h00);
      @(posedge clk);
      irqv <= 5'(1 << i);
      @(posedge clk);
      irqv <= '0;
      #1 chk(take_irq_vec, 1'b1);
    end
    // Low-voltage keep forces light stop; reset pin wakes it
    enter(8'h01, 8'h19, 8'h00);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    restart();
    // Debug allowed: status commands refused, background wakes
    enter(8'h01, 8'h01, 8'h80);
    pulse(4'h2);
    chk(bdc_stop_err, 1'b1);
    pulse(4'h4);
    rd(ADDR_STA, 8'h10);
    pulse(4'h1);
    rd(ADDR_STA, 8'h01);
    // Deep stop with the timer off, woken by the irq pin
    enter(8'h01, 8'h01, 8'h00);
    @(posedge clk);
    ext_irq_pin_n <= 1'b0;
    restart();
    rd(ADDR_PMC, 8'h04);
    rd(ADDR_STA, 8'h21);
    wr(ADDR_PMC, 8'h02);
    rd(ADDR_STA, 8'h01);
    finish_test();
  end
endmodule : tb_ssq_stop_seq
`default_nettype wire
